// File: shared/udma_out_pkg.sv
// constants, state codes and the word checksum for the data-out burst end
// assumes one 25 MHz clock and a host that keeps its side of the burst
package udma_out_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_RP_NS       = 160;
  localparam int T_LI_NS       = 150;
  localparam int T_IORDYZ_NS   = 20;
  localparam int RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LI_CYC        = (T_LI_NS / CLK_PERIOD_NS) < 1 ? 1 : T_LI_NS / CLK_PERIOD_NS;
  localparam int IORDYZ_CYC    = (T_IORDYZ_NS / CLK_PERIOD_NS) < 1 ? 1
                                 : T_IORDYZ_NS / CLK_PERIOD_NS;
  localparam int EXTRA_WORDS   = 3;
  localparam int FIFO_DEPTH    = 16;
  localparam logic [15:0] CRC_SEED   = 16'h4ABA;
  localparam int          ERR_ICRC_BIT = 7;
  localparam int          ERR_ABRT_BIT = 2;
  localparam logic [7:0]  ERR_REPORT = 8'h84;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_DRAIN  = 4'h4,
    ST_TERM   = 4'h8
  } state_t;

  // parallel form of the serial shift, data bit 0 entering first
  function automatic logic [15:0] crc_next(input logic [15:0] c, input logic [15:0] d);
    logic [16:1] f;
    logic [15:0] n;
    f[1]  = d[0] ^ c[15];
    f[2]  = d[1] ^ c[14];
    f[3]  = d[2] ^ c[13];
    f[4]  = d[3] ^ c[12];
    f[5]  = d[4] ^ c[11] ^ f[1];
    f[6]  = d[5] ^ c[10] ^ f[2];
    f[7]  = d[6] ^ c[9] ^ f[3];
    f[8]  = d[7] ^ c[8] ^ f[4];
    f[9]  = d[8] ^ c[7] ^ f[5];
    f[10] = d[9] ^ c[6] ^ f[6];
    f[11] = d[10] ^ c[5] ^ f[7];
    f[12] = d[11] ^ c[4] ^ f[1] ^ f[8];
    f[13] = d[12] ^ c[3] ^ f[2] ^ f[9];
    f[14] = d[13] ^ c[2] ^ f[3] ^ f[10];
    f[15] = d[14] ^ c[1] ^ f[4] ^ f[11];
    f[16] = d[15] ^ c[0] ^ f[5] ^ f[12];
    n[0]  = f[16];
    n[1]  = f[15];
    n[2]  = f[14];
    n[3]  = f[13];
    n[4]  = f[12];
    n[5]  = f[11] ^ f[16];
    n[6]  = f[10] ^ f[15];
    n[7]  = f[9] ^ f[14];
    n[8]  = f[8] ^ f[13];
    n[9]  = f[7] ^ f[12];
    n[10] = f[6] ^ f[11];
    n[11] = f[5] ^ f[10];
    n[12] = f[4] ^ f[9] ^ f[16];
    n[13] = f[3] ^ f[8] ^ f[15];
    n[14] = f[2] ^ f[7] ^ f[14];
    n[15] = f[1] ^ f[6] ^ f[13];
    return n;
  endfunction
endpackage

// File: src/udma_out_term.sv
// device end of a data-out burst: pause, termination, checksum compare
// assumes host pins arrive asynchronously and the user side shares CLOCK_IN
`timescale 1ns/1ns
`default_nettype none

// word buffer with registered output stage
module udma_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic [WIDTH-1:0]           in_data_in,
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  output logic [WIDTH-1:0]                out_data_out,
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  output logic [$clog2(DEPTH+1)-1:0]      free_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 4");
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = (count != '0) && (!out_valid_out || out_ready_in);

  assign in_ready_out = (count != CW'(DEPTH));
  assign free_out     = CW'(DEPTH) - count;

  // storage has no reset; the pointers, count and output stage are reset
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + AW'(1) : wr_ptr;
      rd_ptr <= pop ? rd_ptr + AW'(1) : rd_ptr;
      count  <= count + CW'(push) - CW'(pop);
    end
  end

  // output stage drains the array; out_ready stalls it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem[rd_ptr];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule

module udma_out_term
  import udma_out_pkg::*;
#(
  parameter int LEN_W = 16
) (
  // clock and reset
  input  wire logic             CLOCK_IN,
  input  wire logic             RST_N_IN,
  // host pins
  input  wire logic             DMACK_N_IN,
  input  wire logic             STOP_IN,
  input  wire logic             HSTROBE_IN,
  input  wire logic [15:0]      DATA_IN,
  // device pins
  output logic                  DMARQ_OUT,
  output logic                  DDMARDY_N_OUT,
  output logic                  DDMARDY_OE_OUT,
  // command control
  input  wire logic             CMD_START_IN,
  input  wire logic [LEN_W-1:0] CMD_WORDS_IN,
  input  wire logic             CMD_END_IN,
  input  wire logic             PAUSE_REQ_IN,
  input  wire logic             TERM_REQ_IN,
  // received words
  output logic [15:0]           WORD_DATA_OUT,
  output logic                  WORD_VALID_OUT,
  input  wire logic             WORD_READY_IN,
  // status
  output logic [7:0]            ERROR_OUT,
  output logic [15:0]           HOST_CRC_OUT,
  output logic                  BURST_DONE_OUT
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (LEN_W < 1 || FIFO_DEPTH <= EXTRA_WORDS + 1) begin : g_bad_cfg
    $error("length width or buffer depth too small");
  end

  logic [2:0]       ack_s;
  logic [2:0]       stop_s;
  logic [2:0]       stb_s;
  logic             ack_f;
  logic             stop_f;
  logic             stb_f;
  logic [15:0]      d1;
  logic [15:0]      d2;
  logic [15:0]      d3;
  logic [15:0]      d4;
  state_t           state;
  logic             got_word;
  logic             stop_low_seen;
  logic             host_term;
  logic [7:0]       rp_cnt;
  logic [LEN_W-1:0] words_left;
  logic [15:0]      crc;
  logic             err_flag;
  logic [CW-1:0]    fifo_free;

  // three stages per pin; a change counts once stages two and three agree
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ack_s  <= 3'h7;
      stop_s <= 3'h0;
      stb_s  <= 3'h7;
    end else begin
      ack_s  <= {ack_s[1:0], DMACK_N_IN};
      stop_s <= {stop_s[1:0], STOP_IN};
      stb_s  <= {stb_s[1:0], HSTROBE_IN};
    end
  end

  // data runs one stage deeper so the word is the one sampled before the edge
  always_ff @(posedge CLOCK_IN) begin
    d1 <= DATA_IN;
    d2 <= d1;
    d3 <= d2;
    d4 <= d3;
  end

  // agreed pin levels
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ack_f  <= 1'b1;
      stop_f <= 1'b0;
      stb_f  <= 1'b1;
    end else begin
      ack_f  <= (ack_s[1] == ack_s[2]) ? ack_s[2] : ack_f;
      stop_f <= (stop_s[1] == stop_s[2]) ? stop_s[2] : stop_f;
      stb_f  <= (stb_s[1] == stb_s[2]) ? stb_s[2] : stb_f;
    end
  end

  // edge decode on the agreed levels
  wire stb_edge    = (stb_s[1] == stb_s[2]) && (stb_s[2] != stb_f);
  wire stop_rise   = (stop_s[1] == stop_s[2]) && stop_s[2] && !stop_f;
  wire ack_release = (ack_s[1] == ack_s[2]) && ack_s[2] && !ack_f;
  wire in_data     = (state == ST_ACTIVE) || (state == ST_DRAIN);
  wire accept      = stb_edge && in_data;
  wire store       = accept && (words_left != '0);
  wire pause_cond  = got_word && (PAUSE_REQ_IN
                     || fifo_free <= CW'(EXTRA_WORDS + 1));
  wire end_cond    = got_word && (TERM_REQ_IN || words_left == '0);
  wire start_ok    = (words_left != '0) && !PAUSE_REQ_IN && !TERM_REQ_IN
                     && ack_f && (fifo_free > CW'(EXTRA_WORDS + 1));
  wire host_stop   = (state == ST_ACTIVE) && stop_rise && stop_low_seen;
  wire mismatch    = (d4 != crc);

  // burst sequencing; ready is only ever dropped by this block
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      state          <= ST_IDLE;
      DMARQ_OUT      <= 1'b0;
      DDMARDY_N_OUT  <= 1'b1;
      DDMARDY_OE_OUT <= 1'b0;
      host_term      <= 1'b0;
      rp_cnt         <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          host_term <= 1'b0;
          if (!DMARQ_OUT && start_ok) begin
            DMARQ_OUT <= 1'b1;
          end else if (DMARQ_OUT && !ack_f) begin
            state          <= ST_ACTIVE;
            DDMARDY_OE_OUT <= 1'b1;
          end
        end
        ST_ACTIVE: begin
          if (host_stop) begin
            state         <= ST_TERM;
            DMARQ_OUT     <= 1'b0;
            DDMARDY_N_OUT <= 1'b1;
            host_term     <= 1'b1;
          end else if (end_cond) begin
            state         <= ST_DRAIN;
            DDMARDY_N_OUT <= 1'b1;
            rp_cnt        <= 8'(RP_CYC - 1);
          end else begin
            DDMARDY_N_OUT <= !(stop_low_seen && !pause_cond);
          end
        end
        ST_DRAIN: begin
          // late words still land here while the pause time runs
          if (rp_cnt == 8'h00) begin
            state     <= ST_TERM;
            DMARQ_OUT <= 1'b0;
          end else begin
            rp_cnt <= rp_cnt - 8'h01;
          end
        end
        ST_TERM: begin
          if (ack_release) begin
            state          <= ST_IDLE;
            DDMARDY_OE_OUT <= 1'b0;
          end
        end
        default: begin
          state          <= ST_IDLE;
          DMARQ_OUT      <= 1'b0;
          DDMARDY_N_OUT  <= 1'b1;
          DDMARDY_OE_OUT <= 1'b0;
        end
      endcase
    end
  end

  // per-burst flags
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN || state == ST_IDLE) begin
      got_word      <= 1'b0;
      stop_low_seen <= 1'b0;
    end else begin
      got_word      <= got_word | accept;
      stop_low_seen <= stop_low_seen | !stop_f;
    end
  end

  // checksum seeded while idle, advanced on every data edge
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN || state == ST_IDLE) begin
      crc <= CRC_SEED;
    end else if (accept) begin
      crc <= crc_next(crc, d4);
    end
  end

  // word budget of the command; excess words are counted into the checksum only
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      words_left <= '0;
    end else if (CMD_START_IN) begin
      words_left <= CMD_WORDS_IN;
    end else if (store) begin
      words_left <= words_left - LEN_W'(1);
    end
  end

  // checksum capture and compare; a set in the same cycle beats a new command
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      err_flag       <= 1'b0;
      HOST_CRC_OUT   <= '0;
      BURST_DONE_OUT <= 1'b0;
      ERROR_OUT      <= 8'h00;
    end else begin
      BURST_DONE_OUT <= (state == ST_TERM) && ack_release;
      if ((state == ST_TERM) && ack_release) begin
        HOST_CRC_OUT <= d4;
      end
      if ((state == ST_TERM) && ack_release && mismatch) begin
        err_flag <= 1'b1;
      end else if (CMD_START_IN) begin
        err_flag <= 1'b0;
      end
      if (CMD_START_IN) begin
        ERROR_OUT <= 8'h00;
      end else if (CMD_END_IN) begin
        ERROR_OUT <= err_flag ? ERR_REPORT : 8'h00;
      end
    end
  end

  // a full buffer would drop a word; the pause margin keeps that from happening
  udma_word_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLOCK_IN),
    .rst_n_in      (RST_N_IN),
    .in_data_in    (d4),
    .in_valid_in   (store),
    .in_ready_out  (),
    .out_data_out  (WORD_DATA_OUT),
    .out_valid_out (WORD_VALID_OUT),
    .out_ready_in  (WORD_READY_IN),
    .free_out      (fifo_free)
  );

  // ready may only drop for a pause or an end once a word has arrived
  property p_no_early_pause;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      ($rose(DDMARDY_N_OUT) && !host_term && state != ST_IDLE) |-> got_word;
  endproperty
  a_no_early_pause: assert property (p_no_early_pause)
    else $error("ready dropped before any word");
  property p_rp_gap;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      ($fell(DMARQ_OUT) && !host_term) |-> $past(DDMARDY_N_OUT, RP_CYC);
  endproperty
  a_rp_gap: assert property (p_rp_gap)
    else $error("request dropped too soon after ready");
  property p_host_stop;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      host_stop |=> (!DMARQ_OUT && DDMARDY_N_OUT && state == ST_TERM) [*1];
  endproperty
  a_host_stop: assert property (p_host_stop)
    else $error("request or ready not dropped after host stop");
  property p_term_quiet;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (state == ST_TERM) |-> (!DMARQ_OUT && DDMARDY_N_OUT);
  endproperty
  a_term_quiet: assert property (p_term_quiet)
    else $error("request or ready reasserted during termination");
  property p_release;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      ((state == ST_TERM) && ack_release) |=> !DDMARDY_OE_OUT;
  endproperty
  a_release: assert property (p_release)
    else $error("ready still driven after acknowledge release");
  property p_ignore_return;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      ((state == ST_TERM) && stb_edge) |=> $stable(crc);
  endproperty
  a_ignore_return: assert property (p_ignore_return)
    else $error("strobe return changed the checksum");
  property p_seed;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (state == ST_IDLE) |=> (crc == CRC_SEED);
  endproperty
  a_seed: assert property (p_seed)
    else $error("checksum not seeded between bursts");
  property p_first_err;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      (err_flag && !CMD_START_IN) |=> err_flag;
  endproperty
  a_first_err: assert property (p_first_err)
    else $error("saved checksum error lost within a command");
  property p_capture;
    @(posedge CLOCK_IN) disable iff (!RST_N_IN)
      ((state == ST_TERM) && ack_release) |=> (HOST_CRC_OUT == $past(d4));
  endproperty
  a_capture: assert property (p_capture)
    else $error("host checksum not latched at acknowledge release");
endmodule

`default_nettype wire

// File: test/udma_host_model.sv
// host side of a data-out burst: strobes words, stops, sends its checksum
// assumes the bench loads the word list and limits before the device requests
`timescale 1ns/1ns
`default_nettype none
module udma_host_model (
  input  wire logic        clk_in,
  input  wire logic        clr_in,
  input  wire logic [15:0] words_in [64],
  input  wire logic [5:0]  max_in,
  input  wire logic        bad_in,
  input  wire logic        rq_in,
  input  wire logic        rdy_n_in,
  input  wire logic        oe_in,
  output logic             dmack_n_out,
  output logic             stop_out,
  output logic             strobe_out,
  output logic [15:0]      data_out,
  output logic [15:0]      crc_out
);
  logic [5:0] pos;

  // serial form, bit 0 shifted in first
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
    for (int b = 0; b < 16; b++) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[b]) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction

  // one burst: edges 4 cycles apart, data held 2 cycles each side
  task automatic burst();
    logic [15:0] c;
    int          n;
    c = 16'h4ABA;
    n = 0;
    stop_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    dmack_n_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    stop_out <= 1'b0;
    while (n < max_in && rq_in) begin
      data_out <= words_in[pos];
      repeat (2) @(posedge clk_in);
      // hold the edge back while the device is not ready
      while (rq_in && !(oe_in && !rdy_n_in)) @(posedge clk_in);
      if (rq_in) begin
        strobe_out <= ~strobe_out;
        c = crc_step(c, words_in[pos]);
        pos = pos + 6'h01;
        n++;
        repeat (2) @(posedge clk_in);
      end
    end
    // word limit reached with the request still up: host ends it
    if (rq_in) begin
      repeat (4) @(posedge clk_in);
      stop_out <= 1'b1;
    end
    while (rq_in) @(posedge clk_in);
    stop_out <= 1'b1;
    strobe_out <= 1'b1;
    crc_out <= bad_in ? ~c : c;
    data_out <= bad_in ? ~c : c;
    repeat (4) @(posedge clk_in);
    dmack_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    stop_out <= 1'b0;
    data_out <= ~data_out; // released bus must not keep its value
  endtask

  // idle until the device requests; new command restarts the word list
  initial begin
    dmack_n_out = 1'b1;
    stop_out = 1'b0;
    strobe_out = 1'b1;
    data_out = 16'h0000;
    crc_out = 16'h0000;
    pos = 6'h00;
    forever begin
      @(posedge clk_in);
      if (clr_in) pos = 6'h00;
      else if (rq_in) burst();
    end
  end
endmodule
`default_nettype wire

// File: test/udma_out_term_tb.sv
// bench for the data-out burst end: host model, word stream and status checks
// assumes the host model is compiled first; words and stalls come from xorshift
`timescale 1ns/1ns
`default_nettype none
module udma_out_term_tb;
  import udma_out_pkg::*;
  logic        clk, rst_n, start, cmd_end, pause, term, wready, bad, stall, exp_err;
  logic        dmack_n, stop, strobe, rq, rdy_n, oe, valid, done;
  logic [15:0] nwords, data, wdata, hcrc, mcrc;
  logic [15:0] words [64];
  logic [15:0] exp_q [$];
  logic [7:0]  err;
  logic [5:0]  max_w;
  logic [31:0] seed, rs;
  int          n_mismatch, check_count, n_test, t;

  udma_out_term DUT (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .DMACK_N_IN(dmack_n), .STOP_IN(stop),
    .HSTROBE_IN(strobe), .DATA_IN(data), .DMARQ_OUT(rq), .DDMARDY_N_OUT(rdy_n),
    .DDMARDY_OE_OUT(oe), .CMD_START_IN(start), .CMD_WORDS_IN(nwords),
    .CMD_END_IN(cmd_end), .PAUSE_REQ_IN(pause), .TERM_REQ_IN(term),
    .WORD_DATA_OUT(wdata), .WORD_VALID_OUT(valid), .WORD_READY_IN(wready),
    .ERROR_OUT(err), .HOST_CRC_OUT(hcrc), .BURST_DONE_OUT(done));

  udma_host_model host (
    .clk_in(clk), .clr_in(start), .words_in(words), .max_in(max_w), .bad_in(bad),
    .rq_in(rq), .rdy_n_in(rdy_n), .oe_in(oe), .dmack_n_out(dmack_n),
    .stop_out(stop), .strobe_out(strobe), .data_out(data), .crc_out(mcrc));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // consumer takes words at random, or stalls to fill the buffer
  always @(posedge clk) begin
    rs <= xs(rs);
    wready <= !stall && (rs[3] || rs[9]);
  end

  // each handed-over word is the next wanted one; excess never appears
  always @(posedge clk) begin
    if (valid && wready) begin
      check("word", exp_q.size() > 0 ? exp_q.pop_front() : ~wdata, wdata);
    end
  end

  // burst end: host checksum latched, ready pin released
  always @(posedge clk) begin
    if (done) begin
      check("host crc", mcrc, hcrc);
      check("ready drive", 16'h0000, {15'h0, oe});
      if (bad) exp_err <= 1'b1;
      bad <= 1'b0;
      max_w <= 6'h28;
    end
  end

  // one command: mode 1 pause, 2 device end, 3 buffer stall
  task automatic run_cmd(input int n, input int hmax, input logic b, input int mode);
    logic [31:0] s;
    int          k;
    seed = xs(seed);
    s = seed;
    for (k = 0; k < 64; k++) begin
      s = xs(s);
      words[k] = s[15:0];
    end
    for (k = 0; k < n; k++) exp_q.push_back(words[k]);
    exp_err = 1'b0;
    max_w <= 6'(hmax);
    bad <= b;
    stall <= (mode == 3);
    nwords <= 16'(n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (k = 0; k < 200 && !rq; k++) @(posedge clk);
    pause <= (mode == 1);
    term <= (mode == 2);
    for (k = 0; k < 200 && strobe; k++) @(posedge clk);
    check("first word", 16'h0000, {15'h0, strobe});
    if (mode == 1) begin
      repeat (12) @(posedge clk);
      check("paused", 16'h0001, {15'h0, rdy_n});
      pause <= 1'b0;
      repeat (8) @(posedge clk);
      check("resumed", 16'h0002, {14'h0, oe, rdy_n});
    end
    if (mode == 2) begin
      // ready drops first; request follows exactly the pause time later
      for (k = 0; k < 100 && !rdy_n; k++) @(posedge clk);
      for (k = 0; k < 100 && rq; k++) @(posedge clk);
      check("request gap", 16'(RP_CYC), 16'(k));
      check("ready before request", 16'h0001, {15'h0, rdy_n});
      term <= 1'b0;
    end
    if (mode == 3) begin
      repeat (200) @(posedge clk);
      check("buffer pause", 16'h0001, {15'h0, rdy_n});
      stall <= 1'b0;
    end
    for (k = 0; k < 3000 && (exp_q.size() > 0 || rq || !dmack_n); k++) @(posedge clk);
    check("burst end wait", 16'h0000, 16'(k == 3000));
    check("words left", 16'h0000, 16'(exp_q.size()));
    repeat (8) @(posedge clk);
    cmd_end <= 1'b1;
    @(posedge clk);
    cmd_end <= 1'b0;
    repeat (2) @(posedge clk);
    check("error byte", {8'h00, exp_err ? 8'((1 << ERR_ICRC_BIT) | (1 << ERR_ABRT_BIT))
      : 8'h00}, {8'h00, err});
    n_test++;
    $display("test %0d ended with %0d words", n_test, n);
  endtask

  // hang guard, well beyond the longest expected run
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    $display("wrong value watchdog expected finish seen hang");
    test_done();
  end

  // reset, fixed corner cases, then random commands
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    cmd_end = 1'b0;
    pause = 1'b0;
    term = 1'b0;
    wready = 1'b0;
    bad = 1'b0;
    stall = 1'b0;
    exp_err = 1'b0;
    nwords = 16'h0000;
    max_w = 6'h28;
    seed = 32'h662D691C;
    rs = 32'h662D691C;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    run_cmd(10, 40, 1'b0, 0);
    run_cmd(20, 7, 1'b1, 0);
    run_cmd(12, 40, 1'b0, 1);
    run_cmd(16, 40, 1'b1, 2);
    run_cmd(20, 40, 1'b0, 3);
    run_cmd(1, 40, 1'b0, 0);
    for (t = 0; t < 4; t++) begin
      run_cmd(1 + seed[4:0] % 24, 1 + seed[12:8] % 30, seed[16], 0);
    end
    test_done();
  end
endmodule
`default_nettype wire
